// File: pkg/spe_pkg.sv
// constants and types of the serial eeprom command core
package spe_pkg;
    localparam int SPE_ADDR_W_DEF = 14;
    localparam logic [3:0] SPE_OP_SET_WEL = 4'h6;
    localparam logic [3:0] SPE_OP_CLR_WEL = 4'h4;
    localparam logic [3:0] SPE_OP_RD_STAT = 4'h5;
    localparam logic [3:0] SPE_OP_WR_STAT = 4'h1;
    localparam logic [3:0] SPE_OP_RD_ARR = 4'h3;
    localparam logic [3:0] SPE_OP_WR_ARR = 4'h2;
    localparam int SPE_BIT_BUSY = 0;
    localparam int SPE_BIT_WEL = 1;
    localparam int SPE_BIT_BP_LSB = 2;
    localparam int SPE_BIT_BP_MSB = 3;
    localparam int SPE_BIT_HPE = 7;
    localparam logic [7:0] SPE_STAT_BUSY_VAL = 8'hFF;
    localparam logic [1:0] SPE_BP_RESET = 2'h0;
    localparam logic SPE_HPE_RESET = 1'b0;
    localparam int SPE_PAGE_BYTES = 64;
    localparam int SPE_PAGE_W = 6;
    localparam int SPE_CLK_HZ = 20000000;
    localparam int SPE_TWC_US = 5000;
    localparam int SPE_TWC_CYC = SPE_CLK_HZ / 1000000 * SPE_TWC_US;
    typedef enum logic [2:0] {
        SPE_IDLE, SPE_OPC, SPE_ADDR, SPE_RDATA, SPE_WDATA, SPE_SDATA,
        SPE_RSTAT, SPE_DEAD
    } spe_phase_t;
endpackage : spe_pkg

// File: core/spe_core.sv
// spi serial eeprom command core: decoder, protection, page write, array
// Operation
// - first byte after chip select falls is the 8-bit opcode
// - all bytes move msb first; commands start at chip select fall
// - opcode x110 sets write latch, x100 clears it, bit 3 ignored
// - x101 shifts status out, x001 loads status from si
// - x011 starts array read, x010 starts array write
// - write latch clear after reset; programming needs prior enable
// - write-latch clear works whatever the protect pin level
// - status bit 0 is one while program cycle runs
// - status bit 1 mirrors the write-enable latch
// - bits 6..4 read zero when idle; all ones while busy
// - bit 7 is hardware protect enable, bits 3..2 block protect
// - block protect selects none, top quarter, top half or all
// - protect bits cleared by reset, need write latch and timed cycle
// - pin low and enable bit set refuses every status write
// - protected addresses never programmed; others need the latch
// - read takes 16-bit address, upper bits beyond array ignored
// - read ignores si, streams bytes, address wraps over whole array
// - write needs enable, opcode, address, data outside protection
// - programming starts only if cs rises right after a whole byte
// - page write increments low six bits, wraps within page
// - busy ignores all but status read; latch clears at end
// - write without latch discarded until next chip select fall
// - unknown opcode: no input, so floats until next cs fall
// - cs high: si ignored and so floats
// - pause suspends transfer; si ignored and so floats meanwhile
`timescale 1ns/1ps
module spe_core import spe_pkg::*; #(
    parameter int ADDR_W = SPE_ADDR_W_DEF,
    parameter int TWC_CYC = SPE_TWC_CYC
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic hold_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic busy_o
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cs_s, sck_s, si_s, wp_s, hold_s;
        logic sck_d;
        spe_phase_t ph;
        logic [2:0] bitc;
        logic [7:0] sh;
        logic [3:0] op;
        logic [15:0] addr;
        logic abyte;
        logic pfull;
        logic bound;
        logic [7:0] txb;
        logic so;
        logic oe;
        logic wel;
        logic [1:0] bp;
        logic hpe;
        logic [7:0] nstat;
        logic sprog;
        logic aprog;
        logic busy;
        logic [31:0] tmr;
    } spe_st_t;
    spe_st_t s_r, s_nxt;
    logic [7:0] mem [0:(1<<ADDR_W)-1];
    logic [7:0] pbuf [0:SPE_PAGE_BYTES-1];
    logic pb_we;
    logic [SPE_PAGE_W-1:0] pb_idx;
    logic [7:0] pb_dat;

    // address protected by the block-protect field
    function automatic logic prot(input logic [1:0] bp,
                                  input logic [ADDR_W-1:0] a);
        case (bp)
            2'h1: prot = (a[ADDR_W-1 -: 2] == 2'h3);
            2'h2: prot = a[ADDR_W-1];
            2'h3: prot = 1'b1;
            default: prot = 1'b0;
        endcase
    endfunction : prot

    function automatic logic [7:0] stat(input spe_st_t s);
        stat = s.busy ? SPE_STAT_BUSY_VAL :
            {s.hpe, 3'h0, s.bp, s.wel, 1'b0};
    endfunction : stat

    logic cs_n, sck, si, rise, fall, act;
    logic [7:0] sh_in;
    logic [ADDR_W-1:0] aw, ainc;
    assign cs_n = s_r.cs_s[1];
    assign sck = s_r.sck_s[1];
    assign si = s_r.si_s[1];
    assign act = !cs_n && s_r.hold_s[1];
    assign rise = act && sck && !s_r.sck_d;
    assign fall = act && !sck && s_r.sck_d;
    assign sh_in = {s_r.sh[6:0], si};
    assign aw = s_r.addr[ADDR_W-1:0];
    assign ainc = aw + 1'b1;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        pb_we = 1'b0;
        pb_idx = s_r.addr[SPE_PAGE_W-1:0];
        pb_dat = sh_in;
        s_nxt.cs_s = {s_r.cs_s[0], cs_n_i};
        s_nxt.sck_s = {s_r.sck_s[0], sck_i};
        s_nxt.si_s = {s_r.si_s[0], si_i};
        s_nxt.wp_s = {s_r.wp_s[0], wp_n_i};
        s_nxt.hold_s = {s_r.hold_s[0], hold_n_i};
        s_nxt.sck_d = sck;
        s_nxt.oe = act && (s_r.ph == SPE_RDATA || s_r.ph == SPE_RSTAT)
            && s_r.bound;
        if (s_r.busy) begin
            if (s_r.tmr <= 32'h1) begin
                s_nxt.busy = 1'b0;
                s_nxt.wel = 1'b0;
                s_nxt.tmr = 32'h0;
                if (s_r.sprog) begin
                    s_nxt.bp = s_r.nstat[3:2];
                    s_nxt.hpe = s_r.nstat[7];
                end
            end else begin
                s_nxt.tmr = s_r.tmr - 32'h1;
            end
        end
        if (cs_n) begin
            // cs rise: start programming only on a whole-byte boundary
            if (s_r.ph == SPE_WDATA && s_r.pfull && s_r.bitc == 3'h0
                && s_r.abyte && !s_r.busy) begin
                s_nxt.aprog = 1'b1;
                s_nxt.busy = 1'b1;
                s_nxt.tmr = TWC_CYC;
            end
            if (s_r.ph == SPE_SDATA && s_r.abyte && s_r.bitc == 3'h0
                && !(s_r.hpe && !s_r.wp_s[1])) begin
                s_nxt.sprog = 1'b1;
                s_nxt.busy = 1'b1;
                s_nxt.tmr = TWC_CYC;
            end
            s_nxt.ph = SPE_IDLE;
            s_nxt.bound = 1'b0;
            if (!s_r.busy) begin
                s_nxt.sprog = s_nxt.sprog & s_nxt.busy;
                s_nxt.aprog = s_nxt.aprog & s_nxt.busy;
            end
        end else if (s_r.ph == SPE_IDLE) begin
            s_nxt.ph = SPE_OPC;
            s_nxt.bitc = 3'h0;
            s_nxt.abyte = 1'b0;
            s_nxt.pfull = 1'b0;
        end else if (rise) begin
            s_nxt.sh = sh_in;
            s_nxt.bitc = s_r.bitc + 3'h1;
            if (s_r.bitc == 3'h7) begin
                case (s_r.ph)
                    SPE_OPC: begin
                        s_nxt.op = sh_in[3:0];
                        s_nxt.ph = SPE_DEAD;
                        if (sh_in[7:4] != 4'h0) begin
                            s_nxt.ph = SPE_DEAD;
                        end else if (sh_in[2:0] == SPE_OP_RD_STAT[2:0]) begin
                            s_nxt.ph = SPE_RSTAT;
                            s_nxt.bound = 1'b1;
                            s_nxt.txb = stat(s_r);
                        end else if (s_r.busy) begin
                            s_nxt.ph = SPE_DEAD;
                        end else begin
                            case (sh_in[2:0])
                                SPE_OP_SET_WEL[2:0]: s_nxt.wel = 1'b1;
                                SPE_OP_CLR_WEL[2:0]:
                                    s_nxt.wel = 1'b0;
                                SPE_OP_WR_STAT[2:0]:
                                    if (s_r.wel) s_nxt.ph = SPE_SDATA;
                                SPE_OP_RD_ARR[2:0]: s_nxt.ph = SPE_ADDR;
                                SPE_OP_WR_ARR[2:0]:
                                    if (s_r.wel) begin
                                        s_nxt.ph = SPE_ADDR;
                                    end
                                default: s_nxt.ph = SPE_DEAD;
                            endcase
                        end
                    end
                    SPE_ADDR: begin
                        s_nxt.addr = {s_r.addr[7:0], sh_in};
                        if (s_r.abyte) begin
                            s_nxt.abyte = 1'b0;
                            if (s_r.op[1:0] == SPE_OP_RD_ARR[1:0]) begin
                                s_nxt.ph = SPE_RDATA;
                                s_nxt.bound = 1'b1;
                                s_nxt.txb =
                                    mem[ADDR_W'({s_r.addr[7:0], sh_in})];
                            end else begin
                                s_nxt.ph = SPE_WDATA;
                            end
                        end else begin
                            s_nxt.abyte = 1'b1;
                        end
                    end
                    SPE_WDATA: begin
                        pb_we = 1'b1;
                        s_nxt.abyte = 1'b1;
                        s_nxt.addr[SPE_PAGE_W-1:0] =
                            s_r.addr[SPE_PAGE_W-1:0] + 1'b1;
                        s_nxt.pfull = 1'b1;
                    end
                    SPE_SDATA: begin
                        s_nxt.nstat = sh_in;
                        s_nxt.abyte = 1'b1;
                    end
                    SPE_RDATA: begin
                        s_nxt.addr = 16'(ainc);
                        s_nxt.txb = mem[ainc];
                    end
                    SPE_RSTAT: s_nxt.txb = stat(s_r);
                    default: s_nxt.ph = s_r.ph;
                endcase
            end else if (s_r.ph == SPE_WDATA || s_r.ph == SPE_SDATA) begin
                s_nxt.abyte = 1'b0;
            end
        end
        if (fall && (s_r.ph == SPE_RDATA || s_r.ph == SPE_RSTAT)) begin
            s_nxt.so = s_r.txb[3'h7 - s_r.bitc];
        end
        if (srst_i) begin
            s_nxt = '0;
            s_nxt.ph = SPE_IDLE;
            s_nxt.cs_s = 2'h3;
            s_nxt.wp_s = 2'h3;
            s_nxt.hold_s = 2'h3;
            s_nxt.wel = 1'b0;
            s_nxt.bp = SPE_BP_RESET;
            s_nxt.hpe = SPE_HPE_RESET;
            pb_we = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        s_r <= s_nxt;
    end

    // ----------------------------------------------------------------
    // page buffer and array programming
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (pb_we) pbuf[pb_idx] <= pb_dat;
    end

    // marks which buffered offsets hold new data for this page
    logic [SPE_PAGE_BYTES-1:0] pmark_r;
    always_ff @(posedge ref_clk_i) begin
        // a status poll during the program cycle must keep the marks
        if (srst_i || (s_r.ph == SPE_IDLE && !cs_n && !s_r.busy))
            pmark_r <= '0;
        else if (pb_we) pmark_r[pb_idx] <= 1'b1;
    end

    // commit once at the end of the timed cycle; protected bytes skipped
    always_ff @(posedge ref_clk_i) begin
        if (s_r.aprog && s_r.busy && s_r.tmr == 32'h1) begin
            for (int i = 0; i < SPE_PAGE_BYTES; i++) begin
                if (pmark_r[i] && !prot(s_r.bp,
                    {aw[ADDR_W-1:SPE_PAGE_W], SPE_PAGE_W'(i)}))
                    mem[{aw[ADDR_W-1:SPE_PAGE_W], SPE_PAGE_W'(i)}] <= pbuf[i];
            end
        end
    end

    assign so_o = s_r.so;
    assign so_oe_n_o = !s_r.oe;
    assign busy_o = s_r.busy;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_float_cs;
        @(posedge ref_clk_i) disable iff (srst_i)
        cs_n |=> so_oe_n_o;
    endproperty
    a_float_cs: assert property (p_float_cs)
        else $error("so driven while deselected");
    property p_busy_status;
        @(posedge ref_clk_i) disable iff (srst_i)
        (s_r.busy && s_r.ph == SPE_RSTAT) |-> s_r.txb == SPE_STAT_BUSY_VAL;
    endproperty
    a_busy_status: assert property (p_busy_status)
        else $error("status not all ones while busy");
    property p_wel_end;
        @(posedge ref_clk_i) disable iff (srst_i)
        $fell(s_r.busy) |-> !s_r.wel;
    endproperty
    a_wel_end: assert property (p_wel_end)
        else $error("write latch kept after program cycle");
    property p_hw_prot;
        @(posedge ref_clk_i) disable iff (srst_i)
        ($rose(s_r.sprog) && s_r.hpe) |-> $past(s_r.wp_s[1]);
    endproperty
    a_hw_prot: assert property (p_hw_prot)
        else $error("status write started while hardware protected");
    sequence s_busy_other_opc;
        s_r.busy && rise && s_r.ph == SPE_OPC && s_r.bitc == 3'h7
            && sh_in[7:4] == 4'h0 && sh_in[2:0] != SPE_OP_RD_STAT[2:0];
    endsequence
    property p_busy_ignore;
        @(posedge ref_clk_i) disable iff (srst_i)
        s_busy_other_opc |=> s_r.ph == SPE_DEAD;
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("command taken during program cycle");
    property p_so_fall;
        @(posedge ref_clk_i) disable iff (srst_i)
        !fall |=> $stable(so_o);
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("so changed without a falling sck");
endmodule : spe_core

// File: bench/spe_mst.sv
// spi mode 0 master model that drives the eeprom core pins
`timescale 1ns/1ps
module spe_mst (
    input wire logic ref_clk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    output logic [7:0] rx_byte_o,
    output logic rx_stb_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
        rx_byte_o = 8'h00;
        rx_stb_o = 1'b0;
    end
    // one sck half period is 4 ref_clk cycles, giving a 400 ns sck
    task automatic half();
        repeat (4) @(negedge ref_clk_i);
    endtask : half
    task automatic cs_lo();
        cs_n_o = 1'b0;
        half();
    endtask : cs_lo
    // cs rises inside the sck low phase that follows the last bit
    task automatic cs_hi();
        half();
        cs_n_o = 1'b1;
        half();
        half();
    endtask : cs_hi
    task automatic xfer(input logic [7:0] tx, input bit chk);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            si_o = tx[i];
            half();
            sck_o = 1'b1;
            half();
            rx[i] = so_i;
            sck_o = 1'b0;
        end
        // si flips once released so a stale bit is never mistaken for data
        si_o = ~tx[0];
        rx_byte_o = rx;
        rx_stb_o = chk;
        @(negedge ref_clk_i);
        rx_stb_o = 1'b0;
    endtask : xfer
endmodule : spe_mst

// File: bench/spe_core_tb.sv
// self-checking bench of the serial eeprom command core
`timescale 1ns/1ps
module spe_core_tb;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic wp_n_i = 1'b1;
    logic hold_n = 1'b1;
    logic cs_n, sck, si, so, so_oe_n, busy, rx_stb, so_w;
    logic [7:0] rx_byte, d0, d1, d2, d4, d5;
    logic [7:0] exp_q[$];
    logic [15:0] a;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #25 ref_clk_i = ~ref_clk_i;
    // so has no pull: a released line reads as z and fails any compare
    assign so_w = so_oe_n ? 1'bz : so;
    spe_mst spe_mst_inst (.ref_clk_i(ref_clk_i), .so_i(so_w),
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .rx_byte_o(rx_byte),
        .rx_stb_o(rx_stb));
    spe_core #(.TWC_CYC(400)) spe_core_inst (.ref_clk_i(ref_clk_i),
        .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .wp_n_i(wp_n_i), .hold_n_i(hold_n), .so_o(so), .so_oe_n_o(so_oe_n),
        .busy_o(busy));
    // ---------------------------------------------------------------
    // checking
    // ---------------------------------------------------------------
    task automatic end_of_test();
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    task automatic check_byte(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask : check_byte
    task automatic check_bit(string nm, logic e, logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s exp %b got %b", nm, e, g);
        end
    endtask : check_bit
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (rx_stb)
            check_byte("so byte", exp_q.size() ? exp_q.pop_front() : 8'hXX,
                rx_byte);
        if (cyc == 40000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ---------------------------------------------------------------
    // command tasks
    // ---------------------------------------------------------------
    task automatic cmd(input logic [7:0] op);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(op, 1'b0);
        spe_mst_inst.cs_hi();
    endtask : cmd
    task automatic rd_stat(input logic [7:0] e);
        exp_q.push_back(e);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(8'h05, 1'b0);
        spe_mst_inst.xfer(8'h00, 1'b1);
        spe_mst_inst.cs_hi();
    endtask : rd_stat
    task automatic wr_stat(input logic [7:0] v);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(8'h01, 1'b0);
        spe_mst_inst.xfer(v, 1'b0);
        spe_mst_inst.cs_hi();
    endtask : wr_stat
    // op selects read or write; n bytes follow the 16-bit address
    task automatic arr(input logic [7:0] op, input logic [15:0] ad,
        input logic [7:0] b0, input logic [7:0] b1, input int n);
        logic rd;
        rd = (op == 8'h03);
        if (rd)
            exp_q.push_back(b0);
        if (rd && n == 2)
            exp_q.push_back(b1);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(op, 1'b0);
        spe_mst_inst.xfer(ad[15:8], 1'b0);
        spe_mst_inst.xfer(ad[7:0], 1'b0);
        // during a read si carries noise that must be ignored
        spe_mst_inst.xfer(rd ? 8'($urandom) : b0, rd);
        if (n == 2)
            spe_mst_inst.xfer(rd ? 8'($urandom) : b1, rd);
        spe_mst_inst.cs_hi();
    endtask : arr
    task automatic wait_rdy();
        int k;
        for (k = 0; k < 2000 && busy !== 1'b0; k++)
            @(negedge ref_clk_i);
        if (k == 2000)
            check_bit("busy end", 1'b0, busy);
    endtask : wait_rdy
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        void'($urandom(77));
        {d0, d1, d2} = 24'($urandom);
        // d4 and d5 differ from d0 and each other so refusals are visible
        d4 = ~d0;
        d5 = d0 ^ 8'h55;
        repeat (10) @(negedge ref_clk_i);
        srst_i = 1'b0;
        repeat (4) @(negedge ref_clk_i);
        check_bit("oe_n idle", 1'b1, so_oe_n);
        rd_stat(8'h00);
        // pause between bytes: so floats, then the read resumes intact
        exp_q.push_back(8'h00);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(8'h05, 1'b0);
        repeat (4) @(negedge ref_clk_i);
        hold_n = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        check_bit("oe_n pause", 1'b1, so_oe_n);
        hold_n = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        spe_mst_inst.xfer(8'h00, 1'b1);
        spe_mst_inst.cs_hi();
        cmd(8'h06);
        rd_stat(8'h02);
        wp_n_i = 1'b0;
        cmd(8'h0C);
        rd_stat(8'h00);
        wp_n_i = 1'b1;
        cmd(8'h0E);
        arr(8'h02, 16'hC010, d0, d1, 2);
        check_bit("busy", 1'b1, busy);
        rd_stat(8'hFF);
        cmd(8'h06);
        wait_rdy();
        rd_stat(8'h00);
        arr(8'h03, 16'h0010, d0, d1, 2);
        cmd(8'h06);
        arr(8'h02, 16'h3FFF, d2, d2, 1);
        wait_rdy();
        cmd(8'h06);
        arr(8'h02, 16'h303F, d2, d4, 2);
        wait_rdy();
        cmd(8'h06);
        arr(8'h02, 16'h203F, d2, d4, 2);
        wait_rdy();
        cmd(8'h06);
        arr(8'h02, 16'h003F, d2, d4, 2);
        wait_rdy();
        arr(8'h03, 16'hFFFF, d2, d4, 2);
        arr(8'h02, 16'h0010, d5, d5, 1);
        check_bit("busy no latch", 1'b0, busy);
        arr(8'h03, 16'h0010, d0, d1, 1);
        for (int b = 1; b < 4; b++) begin
            a = (b == 1) ? 16'h3000 : (b == 2) ? 16'h2000 : 16'h0000;
            cmd(8'h06);
            wr_stat({4'h0, 2'(b), 2'h0});
            wait_rdy();
            rd_stat({4'h0, 2'(b), 2'h0});
            cmd(8'h06);
            arr(8'h02, a, d5, d5, 1);
            wait_rdy();
            cmd(8'h04);
            arr(8'h03, a, d4, d4, 1);
            if (b < 3) begin
                cmd(8'h06);
                arr(8'h02, a - 16'h1, d5, d5, 1);
                wait_rdy();
                arr(8'h03, a - 16'h1, d5, d5, 1);
            end
        end
        cmd(8'h06);
        wr_stat(8'h8C);
        wait_rdy();
        rd_stat(8'h8C);
        wp_n_i = 1'b0;
        cmd(8'h06);
        wr_stat(8'h00);
        wait_rdy();
        cmd(8'h04);
        rd_stat(8'h8C);
        wp_n_i = 1'b1;
        cmd(8'h06);
        wr_stat(8'h00);
        wait_rdy();
        rd_stat(8'h00);
        spe_mst_inst.cs_lo();
        spe_mst_inst.xfer(8'h07, 1'b0);
        spe_mst_inst.xfer(8'h05, 1'b0);
        check_bit("oe_n bad op", 1'b1, so_oe_n);
        spe_mst_inst.cs_hi();
        rd_stat(8'h00);
        end_of_test();
    end
endmodule : spe_core_tb
